// file: rtl/sac_pkg.sv
// Shared constants and carriers for the converter control block
package sac_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [15:0] ADDR_RESULT0_LO = 16'hf2d0; // Channel 0 result, low byte
  localparam logic [15:0] ADDR_RESULT0_HI = 16'hf2d1; // Channel 0 result, high byte
  localparam logic [15:0] ADDR_RESULT1_LO = 16'hf2d2; // Channel 1 result, low byte
  localparam logic [15:0] ADDR_RESULT1_HI = 16'hf2d3; // Channel 1 result, high byte
  localparam logic [15:0] ADDR_CTRL_MODE = 16'hf2f0; // adc_control_mode
  localparam logic [15:0] ADDR_CTRL_RUN = 16'hf2f1; // adc_control_run
  localparam logic [15:0] ADDR_CHAN_SEL = 16'hf2f2; // adc_channel_select
  localparam logic [15:0] ADDR_AMP_OFFSET = 16'hf2f4; // amplifier_offset_code
  localparam logic [15:0] ADDR_AMP_GAIN = 16'hf2f5; // amplifier_gain_code
  localparam logic [15:0] ADDR_AMP_CTRL = 16'hf2f6; // amplifier_control

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int REPEAT_SELECT_BIT = 0; // Mode: repeat_select
  localparam int CLOCK_RANGE_BIT = 1; // Mode: clock_range_select
  localparam int CONVERSION_RUN_BIT = 0; // Run: conversion_run
  localparam int CHANNEL0_BIT = 0; // Select: channel0_enable
  localparam int CHANNEL1_BIT = 1; // Select: channel1_enable
  localparam int OFFSET_MEASURE_BIT = 2; // Amp control: offset_measure

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] CTRL_MODE_RST = 2'h2; // Repeat off, fast clock range
  localparam logic [4:0] AMP_OFFSET_RST = 5'h03; // Zero offset
  localparam logic [3:0] AMP_GAIN_RST = 4'h0; // Unity gain
  localparam logic [1:0] AMP_CFG_RST = 2'h0; // Both channels direct

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion timing in clock cycles per clock range
  localparam logic [3:0] SAMPLE_CYC_SLOW = 4'h2; // Sample phase, slow range
  localparam logic [3:0] SAMPLE_CYC_FAST = 4'h8; // Sample phase, fast range
  localparam logic [3:0] BIT_CYC_SLOW = 4'h1; // One decision, slow range
  localparam logic [3:0] BIT_CYC_FAST = 4'h4; // One decision, fast range
  localparam int RESULT_BITS = 12; // Converter resolution

  ////////////////////////////////////////////////////////////////////////////////
  // Amplifier input configurations
  typedef enum logic [1:0] {
    SAC_CFG_DIRECT = 2'b00, // Both channels direct
    SAC_CFG_CH1_AMP = 2'b01, // Channel 0 direct, channel 1 amplified
    SAC_CFG_BOTH_AMP = 2'b10, // Both amplified
    SAC_CFG_DIFF = 2'b11 // Differential across both pins
  } sac_cfg_e;

  // Settings carried to the analog front end
  typedef struct packed {
    logic amp_power; // Amplifiers powered
    logic ch0_amplified; // Channel 0 routed through amplifiers
    logic ch1_amplified; // Channel 1 routed through amplifiers
    logic differential; // First amplifier in use
    logic short_inputs; // Inputs shorted for offset measurement
    logic [3:0] gain_code; // Second amplifier gain
    logic [4:0] offset_code; // Second amplifier offset
  } sac_amp_ctrl_s;

endpackage

// file: rtl/sac_sar_engine.sv
`timescale 1ns/1ns
`default_nettype none
// Successive approximation engine: sample phase then twelve timed decisions
module sac_sar_engine
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic clock_range,
  input wire logic cmp_in,
  output logic done,
  output logic sample,
  output logic [11:0] dac_code,
  output logic [11:0] result
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and storage
  typedef enum logic [1:0] {
    SAC_E_IDLE = 2'b00, // Waiting for a start
    SAC_E_SAMP = 2'b01, // Sample and hold
    SAC_E_BIT = 2'b10 // Bit decisions
  } sac_eng_e;

  sac_eng_e state_r; // Engine state
  sac_eng_e state_nxt; // Next engine state
  logic [3:0] cnt_r; // Cycles left in current phase
  logic [3:0] cnt_nxt; // Next phase count
  logic [3:0] bit_r; // Bit under trial
  logic [3:0] bit_nxt; // Next bit index
  logic [11:0] code_r; // Trial code to the DAC
  logic [11:0] code_nxt; // Next trial code
  logic [11:0] result_r; // Last finished result
  logic [11:0] result_nxt; // Next result
  logic done_r; // Finish pulse
  logic done_nxt; // Next finish pulse
  logic [3:0] samp_len; // Sample length for the range
  logic [3:0] bit_len; // Decision length for the range
  logic [11:0] bit_mask; // One-hot of bit under trial
  logic [11:0] kept_code; // Code after this decision
  logic phase_end; // Phase count ran out
  logic sample_r; // Sample phase flag
  logic sample_nxt; // Next sample flag

  ////////////////////////////////////////////////////////////////////////////////
  // Timing and decision decode
  assign samp_len = clock_range ? SAMPLE_CYC_FAST : SAMPLE_CYC_SLOW;
  assign bit_len = clock_range ? BIT_CYC_FAST : BIT_CYC_SLOW;
  assign bit_mask = 12'h001 << bit_r;
  assign kept_code = cmp_in ? code_r : (code_r & ~bit_mask);
  assign phase_end = (cnt_r == 4'h1);
  assign sample_nxt = (state_nxt == SAC_E_SAMP);

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    bit_nxt = bit_r;
    code_nxt = code_r;
    result_nxt = result_r;
    done_nxt = 1'b0;
    unique case (state_r)
      SAC_E_IDLE: begin
        // Start a fresh sample
        if (start) begin
          state_nxt = SAC_E_SAMP;
          cnt_nxt = samp_len;
        end
      end
      SAC_E_SAMP: begin
        // Hold done, trial the top bit
        if (phase_end) begin
          state_nxt = SAC_E_BIT;
          cnt_nxt = bit_len;
          bit_nxt = 4'hb;
          code_nxt = 12'h800;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      SAC_E_BIT: begin
        // Keep or drop the bit, then trial the next one
        if (phase_end) begin
          cnt_nxt = bit_len;
          if (bit_r == 4'h0) begin
            state_nxt = SAC_E_IDLE;
            result_nxt = kept_code;
            code_nxt = 12'h000;
            done_nxt = 1'b1;
          end else begin
            bit_nxt = bit_r - 4'h1;
            code_nxt = kept_code | (bit_mask >> 1);
          end
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = SAC_E_IDLE;
      end
    endcase
    // Abort drops any conversion at once
    if (abort) begin
      state_nxt = SAC_E_IDLE;
      code_nxt = 12'h000;
      done_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Engine registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SAC_E_IDLE;
      cnt_r <= 4'h0;
      bit_r <= 4'h0;
      code_r <= 12'h000;
      result_r <= 12'h000;
      done_r <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      code_r <= code_nxt;
      result_r <= result_nxt;
      done_r <= done_nxt;
      sample_r <= sample_nxt;
    end
  end

  // Outputs straight from flops
  assign done = done_r;
  assign sample = sample_r;
  assign dac_code = code_r;
  assign result = result_r;

endmodule // sac_sar_engine
`default_nettype wire

// file: rtl/sac_adc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Repeat bit: zero converts once, one repeats
// - Clock range sets cycle counts; resets fast
// - Run bit one starts, zero stops, resets zero
// - Single mode clears run after last channel
// - Select bits enable channels, reset zero
// - Both selected: channel zero then one
// - No channel: powered, idle, run stays one
// - Five-bit offset code, reset three
// - Four-bit gain code, reset zero
// - Direct channels bypass the amplifiers
// - Two-bit amplifier configuration field
// - Amplifiers powered when configuration nonzero
// - Offset-measure bit, reset zero, no effect outside differential
// - Offset measure shorts inputs only when differential
// - Done pulse after last channel; results per channel
// - Result split: high byte, low nibble on top
module sac_adc_ctrl
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_in,
  output logic adc_power,
  output logic sample,
  output logic conv_channel,
  output logic [11:0] dac_code,
  output sac_amp_ctrl_s amp_ctrl,
  output logic conversion_done_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [1:0] {
    SAC_M_IDLE = 2'b00, // Stopped or waiting for run
    SAC_M_CONV = 2'b01, // A channel is converting
    SAC_M_EMPTY = 2'b10 // Running with no channel selected
  } sac_seq_e;

  // Pick the first channel of a pass: lower number first
  function automatic logic first_channel(input logic [1:0] sel);
    first_channel = ~sel[CHANNEL0_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and next values
  logic repeat_select_r; // Repeat mode
  logic repeat_select_nxt;

  logic clock_range_select_r; // Clock range
  logic clock_range_select_nxt;

  logic conversion_run_r; // Run bit
  logic conversion_run_nxt;

  logic [1:0] chan_sel_r; // Channel enables
  logic [1:0] chan_sel_nxt;

  logic [4:0] offset_code_r; // Amplifier offset
  logic [4:0] offset_code_nxt;

  logic [3:0] gain_code_r; // Amplifier gain
  logic [3:0] gain_code_nxt;

  logic [1:0] amp_cfg_r; // Input configuration
  logic [1:0] amp_cfg_nxt;

  logic offset_measure_r; // Offset measurement request
  logic offset_measure_nxt;

  logic [11:0] result0_r; // Channel 0 result
  logic [11:0] result0_nxt;

  logic [11:0] result1_r; // Channel 1 result
  logic [11:0] result1_nxt;

  logic [7:0] rdata_r; // Read data
  logic [7:0] rdata_nxt;

  sac_seq_e state_r; // Sequencer state
  sac_seq_e state_nxt;

  logic chan_r; // Channel being converted
  logic chan_nxt;

  logic eng_start_r; // Engine start pulse
  logic eng_start_nxt;

  logic irq_r; // Completion pulse
  logic irq_nxt;

  logic adc_power_r; // Converter power
  logic adc_power_nxt;

  sac_amp_ctrl_s amp_r; // Front end settings
  sac_amp_ctrl_s amp_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_mode; // Write to mode register
  logic wr_run; // Write to run register
  logic wr_sel; // Write to channel select
  logic wr_offs; // Write to offset code
  logic wr_gain; // Write to gain code
  logic wr_amp; // Write to amplifier control

  logic eng_done; // Engine finished a channel
  logic eng_abort; // Stop the engine now
  logic [11:0] eng_result; // Engine result
  logic last_chan; // Current channel ends the pass
  logic hw_clear_run; // Single pass finished
  sac_cfg_e cfg; // Configuration as enum

  // Address decodes
  assign wr_mode = reg_wr && (reg_addr == ADDR_CTRL_MODE);
  assign wr_run = reg_wr && (reg_addr == ADDR_CTRL_RUN);
  assign wr_sel = reg_wr && (reg_addr == ADDR_CHAN_SEL);
  assign wr_offs = reg_wr && (reg_addr == ADDR_AMP_OFFSET);
  assign wr_gain = reg_wr && (reg_addr == ADDR_AMP_GAIN);
  assign wr_amp = reg_wr && (reg_addr == ADDR_AMP_CTRL);
  assign cfg = sac_cfg_e'(amp_cfg_nxt);

  ////////////////////////////////////////////////////////////////////////////////
  // Software register writes; unused bits are dropped
  assign repeat_select_nxt = wr_mode ? reg_wdata[REPEAT_SELECT_BIT] : repeat_select_r;
  assign clock_range_select_nxt = wr_mode ? reg_wdata[CLOCK_RANGE_BIT] :
                                  clock_range_select_r;
  assign chan_sel_nxt = wr_sel ? reg_wdata[1:0] : chan_sel_r;
  assign offset_code_nxt = wr_offs ? reg_wdata[4:0] : offset_code_r;
  assign gain_code_nxt = wr_gain ? reg_wdata[3:0] : gain_code_r;
  assign amp_cfg_nxt = wr_amp ? reg_wdata[1:0] : amp_cfg_r;
  assign offset_measure_nxt = wr_amp ? reg_wdata[OFFSET_MEASURE_BIT] :
                              offset_measure_r;

  // A software write beats the automatic clear in the same cycle
  assign conversion_run_nxt = wr_run ? reg_wdata[CONVERSION_RUN_BIT] :
                              (hw_clear_run ? 1'b0 : conversion_run_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; result low byte carries its nibble in the top bits
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RESULT0_LO: rdata_nxt = {result0_r[3:0], 4'h0};
        ADDR_RESULT0_HI: rdata_nxt = result0_r[11:4];
        ADDR_RESULT1_LO: rdata_nxt = {result1_r[3:0], 4'h0};
        ADDR_RESULT1_HI: rdata_nxt = result1_r[11:4];

        ADDR_CTRL_MODE: rdata_nxt = {6'h00, clock_range_select_r, repeat_select_r};
        ADDR_CTRL_RUN: rdata_nxt = {7'h00, conversion_run_r};
        ADDR_CHAN_SEL: rdata_nxt = {6'h00, chan_sel_r};
        ADDR_AMP_OFFSET: rdata_nxt = {3'h0, offset_code_r};
        ADDR_AMP_GAIN: rdata_nxt = {4'h0, gain_code_r};
        ADDR_AMP_CTRL: rdata_nxt = {5'h00, offset_measure_r, amp_cfg_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Front end settings
  always_comb begin
    amp_nxt.amp_power = (cfg != SAC_CFG_DIRECT);

    // Direct channels take no gain path
    amp_nxt.ch0_amplified = (cfg == SAC_CFG_BOTH_AMP) ||
                            (cfg == SAC_CFG_DIFF);
    amp_nxt.ch1_amplified = (cfg != SAC_CFG_DIRECT);
    amp_nxt.differential = (cfg == SAC_CFG_DIFF);
    amp_nxt.short_inputs = offset_measure_nxt && (cfg == SAC_CFG_DIFF);

    amp_nxt.gain_code = gain_code_nxt;
    amp_nxt.offset_code = offset_code_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  assign last_chan = (chan_r == 1'b1) || !chan_sel_r[CHANNEL1_BIT];
  assign hw_clear_run = (state_r == SAC_M_CONV) && eng_done && last_chan &&
                        !(chan_r == 1'b0 && chan_sel_r[CHANNEL1_BIT]) && !repeat_select_r;

  assign eng_abort = !conversion_run_r;

  // Pass sequencing
  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    eng_start_nxt = 1'b0;
    irq_nxt = 1'b0;
    result0_nxt = result0_r;
    result1_nxt = result1_r;
    adc_power_nxt = conversion_run_nxt;

    unique case (state_r)
      SAC_M_IDLE: begin
        // Start a pass once the run bit is up
        if (conversion_run_r) begin
          if (chan_sel_r == 2'b00) begin
            state_nxt = SAC_M_EMPTY;
          end else begin
            state_nxt = SAC_M_CONV;
            chan_nxt = first_channel(chan_sel_r);
            eng_start_nxt = 1'b1;
          end
        end
      end

      SAC_M_CONV: begin
        if (!conversion_run_r) begin
          // Software stop abandons the channel
          state_nxt = SAC_M_IDLE;
        end else if (eng_done) begin
          // Store per channel
          if (chan_r) begin
            result1_nxt = eng_result;
          end else begin
            result0_nxt = eng_result;
          end

          if (!chan_r && chan_sel_r[CHANNEL1_BIT]) begin
            // Channel one follows channel zero
            chan_nxt = 1'b1;
            eng_start_nxt = 1'b1;
          end else begin
            irq_nxt = 1'b1;
            if (repeat_select_r) begin
              // Continuous mode begins the next pass
              if (chan_sel_r == 2'b00) begin
                state_nxt = SAC_M_EMPTY;
              end else begin
                chan_nxt = first_channel(chan_sel_r);
                eng_start_nxt = 1'b1;
              end
            end else begin
              state_nxt = SAC_M_IDLE;
            end
          end
        end
      end

      SAC_M_EMPTY: begin
        // Powered but idle until software stops it
        if (!conversion_run_r) begin
          state_nxt = SAC_M_IDLE;
        end
      end

      default: begin
        state_nxt = SAC_M_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-serial converter engine
  sac_sar_engine u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .start(eng_start_r),
    .abort(eng_abort),
    .clock_range(clock_range_select_r),
    .cmp_in(cmp_in),
    .done(eng_done),
    .sample(sample),
    .dac_code(dac_code),
    .result(eng_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      repeat_select_r <= CTRL_MODE_RST[REPEAT_SELECT_BIT];
      clock_range_select_r <= CTRL_MODE_RST[CLOCK_RANGE_BIT];
      conversion_run_r <= 1'b0;
      chan_sel_r <= 2'b00;
      offset_code_r <= AMP_OFFSET_RST;
      gain_code_r <= AMP_GAIN_RST;
      amp_cfg_r <= AMP_CFG_RST;
      offset_measure_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      repeat_select_r <= repeat_select_nxt;
      clock_range_select_r <= clock_range_select_nxt;
      conversion_run_r <= conversion_run_nxt;
      chan_sel_r <= chan_sel_nxt;
      offset_code_r <= offset_code_nxt;
      gain_code_r <= gain_code_nxt;
      amp_cfg_r <= amp_cfg_nxt;
      offset_measure_r <= offset_measure_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Sequencer and output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SAC_M_IDLE;
      chan_r <= 1'b0;
      eng_start_r <= 1'b0;
      irq_r <= 1'b0;
      adc_power_r <= 1'b0;
      result0_r <= 12'h000;
      result1_r <= 12'h000;
      amp_r <= '0;
      amp_r.offset_code <= AMP_OFFSET_RST;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      eng_start_r <= eng_start_nxt;
      irq_r <= irq_nxt;
      adc_power_r <= adc_power_nxt;
      result0_r <= result0_nxt;
      result1_r <= result1_nxt;
      amp_r <= amp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_r;
  assign adc_power = adc_power_r;
  assign conv_channel = chan_r;
  assign amp_ctrl = amp_r;
  assign conversion_done_irq = irq_r;

endmodule // sac_adc_ctrl
`default_nettype wire

// file: bench/sac_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// Analog inputs and comparator facing the converter
module sac_analog_model (
  input wire logic clk,
  input wire logic sample,
  input wire logic conv_channel,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level0,
  input wire logic [11:0] level1,
  output logic cmp_in
);
  logic [11:0] held_r = 12'h000; // Voltage held at end of sample
  logic junk_r = 1'b0; // Meaningless answer while tracking
  ////////////////////////////////////////////////////////////////////////////////
  // Track the selected input during sample, hold it afterwards
  always_ff @(posedge clk) begin
    junk_r <= ~junk_r;
    if (sample) begin
      held_r <= conv_channel ? level1 : level0;
    end
  end
  // Keep the trial bit when the held input is at or above it
  assign cmp_in = sample ? junk_r : (held_r >= dac_code);
endmodule // sac_analog_model
`default_nettype wire

// file: bench/sac_adc_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Port checks for the converter control block
module sac_adc_ctrl_sva
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp_in,
  input wire logic adc_power,
  input wire logic sample,
  input wire logic conv_channel,
  input wire logic [11:0] dac_code,
  input wire sac_amp_ctrl_s amp_ctrl,
  input wire logic conversion_done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire mapped = reg_addr inside {ADDR_RESULT0_LO, ADDR_RESULT0_HI, ADDR_RESULT1_LO,
    ADDR_RESULT1_HI, ADDR_CTRL_MODE, ADDR_CTRL_RUN, ADDR_CHAN_SEL, ADDR_AMP_OFFSET,
    ADDR_AMP_GAIN, ADDR_AMP_CTRL}; // Address hits a register
  ////////////////////////////////////////////////////////////////////////////////
  // Write to one address
  sequence s_wr(logic [15:0] a);
    reg_wr && reg_addr == a;
  endsequence
  // Converter stopped for two cycles
  sequence s_idle;
    !adc_power ##1 !adc_power;
  endsequence
  a_run_power: assert property (s_wr(ADDR_CTRL_RUN) |=> adc_power == $past(reg_wdata[0]))
    else $error("power does not follow run write");
  a_amp_power: assert property (s_wr(ADDR_AMP_CTRL) |=>
    amp_ctrl.amp_power == (|$past(reg_wdata[1:0])))
    else $error("amplifier power wrong");
  a_offset_code: assert property (s_wr(ADDR_AMP_OFFSET) |=>
    amp_ctrl.offset_code == $past(reg_wdata[4:0]))
    else $error("offset code wrong");
  a_short_diff: assert property (s_wr(ADDR_AMP_CTRL) |=>
    amp_ctrl.short_inputs == (&$past(reg_wdata[2:0])))
    else $error("inputs shorted outside differential");
  a_bypass_map: assert property (s_wr(ADDR_AMP_CTRL) |=>
    amp_ctrl.ch0_amplified == $past(reg_wdata[1]))
    else $error("amplifier routing wrong");
  a_unmapped_read: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_pulse: assert property (conversion_done_irq |=>
    !conversion_done_irq && $past(adc_power, 2))
    else $error("done pulse wrong");
  a_idle_quiet: assert property (s_idle |-> dac_code == 12'h000 && !sample)
    else $error("converter busy while stopped");
  a_sample_min: assert property ($rose(sample) |=> sample || !adc_power)
    else $error("sample phase too short");
endmodule // sac_adc_ctrl_sva
bind sac_adc_ctrl sac_adc_ctrl_sva i_sac_adc_ctrl_sva (.clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .cmp_in, .adc_power, .sample, .conv_channel, .dac_code,
  .amp_ctrl, .conversion_done_irq);
`default_nettype wire

// file: bench/sac_adc_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the converter control block
module sac_adc_ctrl_tb_top
  import sac_pkg::*;
();
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Clock, reset, strobes
  logic [15:0] reg_addr = 16'h0000; // Bus address
  logic [7:0] reg_wdata = 8'h00; // Bus write data
  logic [7:0] reg_rdata, d, v; // Read data and scratch
  logic cmp_in, adc_power, sample, conv_channel, conversion_done_irq; // Comparator answer and design outputs
  logic [11:0] dac_code, level0 = 12'h000, level1 = 12'h000; // Trial code, inputs
  sac_amp_ctrl_s amp_ctrl; // Front-end settings
  int bad_count = 0, check_count = 0, irq_cnt = 0, sam_cnt = 0, cyc = 0, n; // Counters
  logic [3:0] ch_log = 4'h0; // Channels in sampling order
  logic sample_q = 1'b0; // Sample one cycle ago
  logic [1:0] sel; // Channel selection in use
  localparam logic [15:0] ADDRS [10] = '{ADDR_CTRL_MODE, ADDR_CTRL_RUN, ADDR_CHAN_SEL,
    ADDR_AMP_OFFSET, ADDR_AMP_GAIN, ADDR_AMP_CTRL, ADDR_RESULT0_LO, ADDR_RESULT0_HI,
    ADDR_RESULT1_HI, 16'hf2f3};
  localparam logic [7:0] RSTV [10] = '{8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MASK [10] = '{8'h03, 8'h01, 8'h03, 8'h1f, 8'h0f, 8'h07, 8'h00,
    8'h00, 8'h00, 8'h00};
  always #20 clk = ~clk;
  sac_adc_ctrl i_sac_adc_ctrl (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cmp_in, .adc_power, .sample, .conv_channel, .dac_code, .amp_ctrl,
    .conversion_done_irq);
  sac_analog_model i_sac_analog_model (.clk, .sample, .conv_channel, .dac_code, .level0,
    .level1, .cmp_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Count done pulses and sample phases, cut a hang short
  always @(posedge clk) begin
    sample_q <= sample;
    cyc <= cyc + 1;
    if (conversion_done_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (sample === 1'b1 && sample_q === 1'b0) begin
      sam_cnt <= sam_cnt + 1;
      ch_log <= {ch_log[2:0], conv_channel};
    end
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // Compare a port value
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare a register byte
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_sig({8'h00, got}, {8'h00, exp});
  endtask
  // Print counts and verdict
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Register write
  task automatic wr(input logic [15:0] a, input logic [7:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Register read, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] r);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge clk);
  endtask
  // Wait for one done pulse within a bound
  task automatic wait_irq();
    int s;
    s = irq_cnt;
    for (int i = 0; i < 400 && irq_cnt == s; i++) begin
      @(posedge clk);
      #1;
    end
    chk_sig(16'(irq_cnt - s), 16'h0001);
  endtask
  // Expected front-end settings
  function automatic sac_amp_ctrl_s exp_amp(logic [2:0] c, logic [3:0] g, logic [4:0] o);
    return '{amp_power: |c[1:0], ch0_amplified: c[1], ch1_amplified: |c[1:0],
      differential: &c[1:0], short_inputs: c[2] & (&c[1:0]), gain_code: g, offset_code: o};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n = $urandom(48);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1 chk_sig({2'b00, amp_ctrl}, {2'b00, exp_amp(3'h0, 4'h0, 5'h03)});
    for (int i = 0; i < 10; i++) begin
      rd(ADDRS[i], d);
      chk_reg(d, RSTV[i]);
    end
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom);
      if (i != 1) wr(ADDRS[i], v);
      rd(ADDRS[i], d);
      chk_reg(d, (i == 1) ? 8'h00 : v & MASK[i]);
    end
    for (int c = 0; c < 8; c++) begin
      v = 8'($urandom);
      wr(ADDR_AMP_GAIN, v);
      wr(ADDR_AMP_OFFSET, ~v);
      wr(ADDR_AMP_CTRL, 8'(c));
      #1 chk_sig({2'b00, amp_ctrl}, {2'b00, exp_amp(3'(c), v[3:0], ~v[4:0])});
    end
    repeat (20) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      sel = 2'(i % 3 + 1);
      level0 <= (i == 0) ? 12'hfff : 12'($urandom);
      level1 <= (i == 0) ? 12'h000 : 12'($urandom);
      wr(ADDR_CTRL_MODE, (i < 3) ? 8'h02 : 8'h00);
      wr(ADDR_CHAN_SEL, {6'h00, sel});
      n = sam_cnt;
      wr(ADDR_CTRL_RUN, 8'h01);
      wait_irq();
      chk_sig(16'(sam_cnt - n), 16'(sel[0]) + 16'(sel[1]));
      chk_sig({15'h0, ch_log[0]}, {15'h0, sel[1]});
      if (sel == 2'h3) chk_sig({15'h0, ch_log[1]}, 16'h0000);
      rd(ADDR_CTRL_RUN, d);
      chk_reg(d, 8'h00);
      for (int c = 0; c < 2; c++) begin
        if (sel[c]) begin
          rd(c ? ADDR_RESULT1_LO : ADDR_RESULT0_LO, d);
          chk_reg(d, {(c ? level1[3:0] : level0[3:0]), 4'h0});
          rd(c ? ADDR_RESULT1_HI : ADDR_RESULT0_HI, d);
          chk_reg(d, c ? level1[11:4] : level0[11:4]);
        end
      end
    end
    wr(ADDR_AMP_CTRL, 8'h00);
    wr(ADDR_CTRL_MODE, 8'h03);
    wr(ADDR_CHAN_SEL, 8'h01);
    wr(ADDR_CTRL_RUN, 8'h01);
    wait_irq();
    wait_irq();
    rd(ADDR_CTRL_RUN, d);
    chk_reg(d, 8'h01);
    wr(ADDR_CTRL_RUN, 8'h00);
    n = irq_cnt;
    repeat (100) @(posedge clk);
    #1 chk_sig(16'(irq_cnt - n), 16'h0000);
    chk_sig({3'b000, adc_power, dac_code}, 16'h0000);
    wr(ADDR_CHAN_SEL, 8'h00);
    n = irq_cnt;
    wr(ADDR_CTRL_RUN, 8'h01);
    repeat (200) @(posedge clk);
    #1 chk_sig({14'h0, adc_power, sample}, 16'h0002);
    chk_sig(16'(irq_cnt - n), 16'h0000);
    rd(ADDR_CTRL_RUN, d);
    chk_reg(d, 8'h01);
    complete_run();
  end
endmodule // sac_adc_ctrl_tb_top
`default_nettype wire
